// ===== dvib_consts.svh
// Purpose: constants for the dq reference / invert / bank mask register block
// Assumes: six-bit mode register index, eight-bit operand
// Notes:   offsets, field positions, reset values
`ifndef DVIB_CONSTS_SVH
`define DVIB_CONSTS_SVH
`define DVIB_IDX_SET_POINT_CTRL  6'h0D
`define DVIB_IDX_DQ_REF_LEVEL    6'h0E
`define DVIB_IDX_LOWER_INVERT    6'h0F
`define DVIB_IDX_BANK_MASK       6'h10
`define DVIB_SPC_WRITE_SEL_BIT   6
`define DVIB_SPC_OPERATE_BIT     7
`define DVIB_REF_RANGE_BIT       6
`define DVIB_REF_CODE_MAX        6'h32
`define DVIB_REF_RESET           8'h4D
`define DVIB_INVERT_RESET        8'h55
`define DVIB_MASK_RESET          8'h00
`define DVIB_SPC_RESET           8'h00
`endif

// ===== dvib_ctrl_model.sv
// Purpose: controller model issuing mode register commands
// Assumes: drives at falling edge
// Notes: idle index and operand show inverted last value, strobes low
`timescale 1ns/1ps
`default_nettype none
module dvib_ctrl_model
    import dvib_pkg::*;
(
    // command
    input wire logic          mclk,
    output logic              mr_write,
    output logic              mr_read,
    output dvib_index_t       mode_register_index,
    output dvib_operand_t     register_operand,
    // answer
    input wire logic          mr_read_valid,
    input wire dvib_operand_t mr_read_data
);
    initial {mr_write, mr_read, mode_register_index, register_operand} = 16'h0000;
    task automatic issue(input logic w, input dvib_index_t i, input dvib_operand_t d,
                         output dvib_operand_t q);
        @(negedge mclk);
        {mr_write, mr_read, mode_register_index, register_operand} = {w, !w, i, d};
        @(negedge mclk);
        {mr_write, mr_read, mode_register_index, register_operand} = {2'h0, ~i, ~d};
        q = mr_read_valid ? mr_read_data : 8'hXX;
    endtask
endmodule // dvib_ctrl_model
`default_nettype wire

// ===== dvib_pkg.sv
// Purpose: shared types for the dq reference / invert / bank mask block
// Assumes: nothing
// Notes:   numeric constants live in dvib_consts.svh
package dvib_pkg;
    typedef logic [7:0] dvib_operand_t;
    typedef logic [5:0] dvib_index_t;
endpackage

// ===== dvib_ref_copy.sv
// Purpose: one set-point copy of the dq reference level register
// Assumes: synchronous active-high reset
// Notes:   bit 7 reserved, held at zero
`timescale 1ns/1ps
`default_nettype none
`include "dvib_consts.svh"
module dvib_ref_copy
    import dvib_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // register port
    dvib_ref_if.owner rif
);
    dvib_operand_t value_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            value_r <= `DVIB_REF_RESET;
        end else if (rif.wr_en) begin
            value_r <= {1'b0, rif.wr_data[6:0]};
        end
    end
    assign rif.value = value_r;
endmodule // dvib_ref_copy
`default_nettype wire

// ===== dvib_ref_if.sv
// Purpose: carries one set point's write strobe and stored value
// Assumes: single clock
// Notes:   used between the top and each set-point copy
`timescale 1ns/1ps
`default_nettype none
interface dvib_ref_if;
    logic                  wr_en;
    dvib_pkg::dvib_operand_t wr_data;
    dvib_pkg::dvib_operand_t value;
    modport owner (input wr_en, input wr_data, output value);
    modport user  (output wr_en, output wr_data, input value);
endinterface
`default_nettype wire

// ===== dvib_regs.sv
// Purpose: dq reference, lower-byte invert and bank refresh mask registers
// Assumes: mode register writes/reads arrive as one-cycle strobes with index
// Notes:   one instance per channel gives each channel its own bank mask
`timescale 1ns/1ps
`default_nettype none
`include "dvib_consts.svh"
module dvib_regs
    import dvib_pkg::*;
#(
    parameter int LANES = 8
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // mode register command
    input  wire logic          mr_write,
    input  wire logic          mr_read,
    input  wire dvib_index_t   mode_register_index,
    input  wire dvib_operand_t register_operand,
    output logic               mr_read_valid,
    output dvib_operand_t      mr_read_data,
    output logic               mr_code_reserved,
    // calibration
    input  wire logic          cal_active,
    input  wire logic          cal_beat_sel,
    input  wire dvib_operand_t calibration_pattern_a,
    input  wire dvib_operand_t calibration_pattern_b,
    input  wire logic          bus_inversion_read_en,
    output dvib_operand_t      cal_dq_out,
    output logic               cal_mask_inversion_lane,
    output logic               bus_inversion_active,
    // operating state
    output logic               set_point_operate,
    output logic               dq_ref_range,
    output logic [5:0]         dq_ref_code,
    output dvib_operand_t      bank_refresh_enable
);
    // elaboration-time refusal of lane counts the byte-wide logic cannot serve
    if (LANES != 8) begin : g_lanes_check
        $error("dvib_regs: LANES must be 8");
    end

    dvib_operand_t set_point_ctrl_r;
    dvib_operand_t lower_invert_r;
    dvib_operand_t bank_mask_r;
    dvib_operand_t cal_dq_r;
    logic          cal_dmi_r;
    logic          rd_valid_r;
    dvib_operand_t rd_data_r;
    logic          reserved_r;
    logic          ref_wr;
    logic          wsel;
    dvib_operand_t pattern;

    dvib_ref_if ref0 ();
    dvib_ref_if ref1 ();

    dvib_ref_copy u_ref0 (.mclk(mclk), .rst(rst), .rif(ref0));
    dvib_ref_copy u_ref1 (.mclk(mclk), .rst(rst), .rif(ref1));

    assign wsel = set_point_ctrl_r[`DVIB_SPC_WRITE_SEL_BIT];
    assign ref_wr = mr_write && (mode_register_index == `DVIB_IDX_DQ_REF_LEVEL);
    assign ref0.wr_en   = ref_wr && !wsel;
    assign ref1.wr_en   = ref_wr && wsel;
    assign ref0.wr_data = register_operand;
    assign ref1.wr_data = register_operand;

    // set-point control register
    always_ff @(posedge mclk) begin
        if (rst) begin
            set_point_ctrl_r <= `DVIB_SPC_RESET;
        end else if (mr_write && mode_register_index == `DVIB_IDX_SET_POINT_CTRL) begin
            set_point_ctrl_r <= register_operand;
        end
    end

    // lower-byte invert register
    always_ff @(posedge mclk) begin
        if (rst) begin
            lower_invert_r <= `DVIB_INVERT_RESET;
        end else if (mr_write && mode_register_index == `DVIB_IDX_LOWER_INVERT) begin
            lower_invert_r <= register_operand;
        end
    end

    // bank refresh mask, per channel instance
    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_mask_r <= `DVIB_MASK_RESET;
        end else if (mr_write && mode_register_index == `DVIB_IDX_BANK_MASK) begin
            bank_mask_r <= register_operand;
        end
    end

    // flag a reserved reference code on write
    always_ff @(posedge mclk) begin
        if (rst) begin
            reserved_r <= 1'b0;
        end else if (ref_wr) begin
            reserved_r <= (register_operand[5:0] > `DVIB_REF_CODE_MAX);
        end
    end

    // mode register read
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= 8'h00;
        end else begin
            rd_valid_r <= mr_read;
            if (mr_read) begin
                if (mode_register_index == `DVIB_IDX_DQ_REF_LEVEL) begin
                    rd_data_r <= wsel ? ref1.value : ref0.value;
                end else if (mode_register_index == `DVIB_IDX_SET_POINT_CTRL) begin
                    rd_data_r <= set_point_ctrl_r;
                end else begin
                    rd_data_r <= 8'h00;
                end
            end
        end
    end

    // calibration pattern output
    assign pattern = cal_beat_sel ? calibration_pattern_b : calibration_pattern_a;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cal_dq_r  <= 8'h00;
            cal_dmi_r <= 1'b0;
        end else if (cal_active) begin
            cal_dq_r  <= pattern ^ lower_invert_r;
            cal_dmi_r <= pattern[0];
        end else begin
            cal_dq_r  <= 8'h00;
            cal_dmi_r <= 1'b0;
        end
    end

    assign mr_read_valid           = rd_valid_r;
    assign mr_read_data            = rd_data_r;
    assign mr_code_reserved        = reserved_r;
    assign cal_dq_out              = cal_dq_r;
    assign cal_mask_inversion_lane = cal_dmi_r;
    assign bus_inversion_active    = bus_inversion_read_en && !cal_active;
    assign set_point_operate       = set_point_ctrl_r[`DVIB_SPC_OPERATE_BIT];
    assign dq_ref_range = set_point_operate ? ref1.value[`DVIB_REF_RANGE_BIT]
                                            : ref0.value[`DVIB_REF_RANGE_BIT];
    assign dq_ref_code  = set_point_operate ? ref1.value[5:0] : ref0.value[5:0];
    assign bank_refresh_enable     = ~bank_mask_r;
endmodule // dvib_regs
`default_nettype wire

// ===== dvib_regs_chk.sv
// Purpose: port checks for dvib_regs
// Assumes: sync active-high rst
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module dvib_regs_chk
    import dvib_pkg::*;
(
    // command side
    input wire logic          mclk, rst, mr_write, mr_read, mr_read_valid, mr_code_reserved,
    input wire dvib_index_t   mode_register_index,
    input wire dvib_operand_t register_operand, mr_read_data, bank_refresh_enable,
    // calibration and state
    input wire logic          cal_active, cal_beat_sel, bus_inversion_read_en, dq_ref_range,
    input wire logic          bus_inversion_active, cal_mask_inversion_lane, set_point_operate,
    input wire logic [5:0]    dq_ref_code,
    input wire dvib_operand_t calibration_pattern_a, cal_dq_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_wo_read_zero: assert property (mr_read && mode_register_index inside {6'h0F, 6'h10}
        |=> mr_read_valid && mr_read_data == 8'h00) else $error("write-only read not zero");
    a_mask_write: assert property (mr_write && mode_register_index == 6'h10
        |=> bank_refresh_enable == ~$past(register_operand)) else $error("bank mask wrong");
    a_operate_bit: assert property (mr_write && mode_register_index == 6'h0D
        |=> set_point_operate == $past(register_operand[7])) else $error("operate bit wrong");
    a_code_flag: assert property (mr_write && mode_register_index == 6'h0E
        |=> mr_code_reserved == ($past(register_operand[5:0]) > 6'h32)) else $error("code flag");
    a_no_bus_inv: assert property (
        bus_inversion_active == (bus_inversion_read_en && !cal_active))
        else $error("bus inversion during calibration");
    a_lane_true: assert property (cal_active && !cal_beat_sel
        |=> cal_mask_inversion_lane == $past(calibration_pattern_a[0]))
        else $error("lane inverted");
    a_cal_idle: assert property (!cal_active |=> cal_dq_out == 8'h00)
        else $error("cal not idle");
    a_reset_vals: assert property ($fell(rst) |-> bank_refresh_enable == 8'hFF
        && dq_ref_range && dq_ref_code == 6'h0D && !set_point_operate)
        else $error("reset values wrong");
    cover property (mr_read ##1 mr_read_valid);
    cover property (cal_active && cal_beat_sel);
    cover property (mr_write && mode_register_index == 6'h0E);
endmodule // dvib_regs_chk
bind dvib_regs dvib_regs_chk dvib_regs_chk_i (.*);
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for dvib_regs
// Assumes: 125 MHz mclk, sync rst
// Notes: int model compared after every read command
`timescale 1ns/1ps
`default_nettype none
module tb
    import dvib_pkg::*;
;
    logic mclk = 0, rst = 1, mr_write, mr_read, mr_read_valid, mr_code_reserved;
    logic cal_active = 0, cal_beat_sel = 0, bus_inversion_read_en = 1, dq_ref_range;
    logic cal_mask_inversion_lane, bus_inversion_active, set_point_operate;
    logic [5:0] dq_ref_code;
    dvib_index_t mode_register_index, idx;
    dvib_operand_t register_operand, mr_read_data, cal_dq_out, bank_refresh_enable, rd;
    dvib_operand_t calibration_pattern_a = 8'h00, calibration_pattern_b = 8'h00;
    int miscompares = 0, comparisons = 0, inv = 8'h55, msk = 0, spc = 0, op, p;
    int refc[2] = '{8'h4D, 8'h4D};
    always #4 mclk = ~mclk;
    dvib_regs dvib_regs_i (.*);
    dvib_ctrl_model dvib_ctrl_model_i (.*);
    task automatic chk(input string n, input dvib_operand_t e, input dvib_operand_t g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic state_and_cal(input logic b);
        chk("bank_en", 8'(~msk), bank_refresh_enable);
        p = refc[spc >> 7] | spc & 8'h80;
        chk("ref_op", 8'(p), {set_point_operate, dq_ref_range, dq_ref_code});
        chk("bus_inv", {7'h00, bus_inversion_read_en}, {7'h00, bus_inversion_active});
        @(negedge mclk);
        {cal_active, cal_beat_sel, bus_inversion_read_en} = {1'b1, b, 1'($urandom)};
        {calibration_pattern_a, calibration_pattern_b} = 16'($urandom);
        @(negedge mclk);
        p = b ? calibration_pattern_b : calibration_pattern_a;
        chk("cal_dq", 8'(p ^ inv), cal_dq_out);
        chk("dmi", 8'(p & 1), {7'h00, cal_mask_inversion_lane});
        chk("bus_inv_cal", 8'h00, {7'h00, bus_inversion_active});
        cal_active = 0;
    endtask
    initial begin
        void'($urandom(32'h9A09));
        repeat (5) @(negedge mclk);
        rst = 0;
        state_and_cal(0);
        for (int i = 0; i < 48; i++) begin
            idx = 6'(8'h0D + i % 4);
            op = $urandom & 8'hFF;
            if (idx == 6'h0E) op = op & 8'h40 | (i == 5 ? 8'h33 : $urandom_range(0, 50));
            dvib_ctrl_model_i.issue(1, idx, 8'(op), rd);
            case (idx)
                6'h0D: spc = op;
                6'h0E: refc[spc >> 6 & 1] = op & 8'h7F;
                6'h0F: inv = op;
                default: msk = op;
            endcase
            if (idx == 6'h0E) chk("reserved", 8'(i == 5), {7'h00, mr_code_reserved});
            dvib_ctrl_model_i.issue(0, idx, 8'h00, rd);
            p = idx == 6'h0D ? spc : idx == 6'h0E ? refc[spc >> 6 & 1] : 0;
            chk("read", 8'(p), rd);
            dvib_ctrl_model_i.issue(0, 6'(idx + 6'h30), 8'h00, rd);
            chk("unmapped", 8'h00, rd);
            state_and_cal(i[0]);
        end
        // mid-run reset must restore each register's reset value; of the two reference copies, only set-point 0 is checked
        @(negedge mclk);
        rst = 1;
        repeat (2) @(negedge mclk);
        rst = 0;
        inv = 8'h55;
        msk = 0;
        spc = 0;
        refc = '{8'h4D, 8'h4D};
        chk("reserved", 8'h00, {7'h00, mr_code_reserved});
        state_and_cal(1);
        dvib_ctrl_model_i.issue(0, 6'h0E, 8'h00, rd);
        chk("read", 8'h4D, rd);
        report_and_stop;
    end
    initial begin
        #50000;
        miscompares++;
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
